// ### rtl/eprl_pkg.sv
// constants and types for the echo profile record library
// What this block does
// - ten profile slots, manual or automatic origin
// - library full: auto replaces oldest auto
// - auto capture never replaces manual records
// - power interruption clears every slot
// - displayed results use present settings
// - per-slot status: empty, A1, A2, U1, U2
// - capture command fills single display buffer
// - save copies buffer to slot as manual
// - clear then enter empties selected slot
// - auto capture enable gates automatic path
// - source select: any, transducer one, two
// - minimum interval in minutes between auto saves
// - level must lie within on/off band
// - unset setpoint skips level band check
// - setpoints range -999 to 9999
// - direction filter: either, filling, emptying
// - filling/emptying needs rate beyond threshold
// - nonzero echo-loss time must be exceeded
// - zero echo-loss time needs no echo loss
package eprl_pkg;
   localparam int SLOT_COUNT    = 10;
   localparam int SLOT_IDX_W    = 4;
   localparam int PROFILE_W     = 32;
   localparam int LEVEL_W       = 16;
   localparam int MINUTES_W     = 14;
   localparam int SECONDS_W     = 14;
   localparam int AGE_W         = 16;
   localparam int CLK_HZ        = 100_000_000;
   localparam int ONE_SECOND_NS = 1_000_000_000;
   localparam int CLK_PERIOD_NS = ONE_SECOND_NS / CLK_HZ;
   localparam int SECOND_CYCLES = ONE_SECOND_NS / CLK_PERIOD_NS;
   localparam int SEC_PER_MIN   = 60;
   localparam logic [LEVEL_W-1:0]   LEVEL_MIN   = 16'hFC19;
   localparam logic [LEVEL_W-1:0]   LEVEL_MAX   = 16'h270F;
   localparam logic [LEVEL_W-1:0]   LEVEL_UNSET = 16'h8000;
   localparam logic [MINUTES_W-1:0] INTERVAL_DEFAULT = 14'h0078;
   localparam logic [SECONDS_W-1:0] ECHO_LOSS_DEFAULT = 14'h0000;

   typedef enum logic [2:0] {
      EPRL_ST_EMPTY = 3'h0,
      EPRL_ST_A1    = 3'h1,
      EPRL_ST_A2    = 3'h2,
      EPRL_ST_U1    = 3'h3,
      EPRL_ST_U2    = 3'h4
   } eprl_status_type;

   typedef enum logic [1:0] {
      EPRL_SRC_ANY = 2'h0,
      EPRL_SRC_ONE = 2'h1,
      EPRL_SRC_TWO = 2'h2
   } eprl_source_type;

   typedef enum logic [1:0] {
      EPRL_DIR_EITHER = 2'h0,
      EPRL_DIR_FILL   = 2'h1,
      EPRL_DIR_EMPTY  = 2'h2
   } eprl_dir_type;

   typedef enum logic [3:0] {
      EPRL_FSM_IDLE    = 4'h1,
      EPRL_FSM_FIRE    = 4'h2,
      EPRL_FSM_CLEARED = 4'h4,
      EPRL_FSM_AUTO    = 4'h8
   } eprl_fsm_type;
endpackage

// ### rtl/eprl_tick.sv
// seconds and minutes tick generator
`timescale 1ns/10ps
`default_nettype none
module eprl_tick (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // ticks
   output logic      sec_tick,
   output logic      min_tick
);
   logic [26:0] cyc_reg;
   logic [5:0]  sec_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cyc_reg  <= 27'h0000000;
         sec_tick <= 1'b0;
      end else if (cyc_reg == 27'(eprl_pkg::SECOND_CYCLES - 1)) begin
         cyc_reg  <= 27'h0000000;
         sec_tick <= 1'b1;
      end else begin
         cyc_reg  <= cyc_reg + 27'h0000001;
         sec_tick <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sec_reg  <= 6'h00;
         min_tick <= 1'b0;
      end else begin
         min_tick <= 1'b0;
         if (sec_tick) begin
            if (sec_reg == 6'(eprl_pkg::SEC_PER_MIN - 1)) begin
               sec_reg  <= 6'h00;
               min_tick <= 1'b1;
            end else begin
               sec_reg <= sec_reg + 6'h01;
            end
         end
      end
   end
endmodule // eprl_tick
`default_nettype wire

// ### rtl/eprl_library.sv
// echo profile record library with manual and automatic capture
`timescale 1ns/10ps
`default_nettype none
module eprl_library (
   // clock and reset (reset also models power interruption)
   input  wire logic                              clk,
   input  wire logic                              rst,
   // operator keypad
   input  wire logic [eprl_pkg::SLOT_IDX_W-1:0]   slot_select,
   input  wire logic                              key_capture,
   input  wire logic                              key_save,
   input  wire logic                              key_clear,
   input  wire logic                              key_enter,
   input  wire logic                              capture_point,
   // echo processor
   output logic                                   fire_req,
   input  wire logic                              profile_valid,
   input  wire logic [eprl_pkg::PROFILE_W-1:0]    profile_data,
   input  wire logic                              profile_point,
   input  wire logic signed [eprl_pkg::LEVEL_W-1:0] level_value,
   input  wire logic signed [eprl_pkg::LEVEL_W-1:0] level_rate,
   input  wire logic                              echo_loss_condition,
   // configuration
   input  wire logic                              auto_capture_enable,
   input  wire logic [1:0]                        auto_capture_source_select,
   input  wire logic [eprl_pkg::MINUTES_W-1:0]    auto_capture_min_interval,
   input  wire logic signed [eprl_pkg::LEVEL_W-1:0] auto_capture_band_on_level,
   input  wire logic signed [eprl_pkg::LEVEL_W-1:0] auto_capture_band_off_level,
   input  wire logic [1:0]                        auto_capture_direction_filter,
   input  wire logic [eprl_pkg::SECONDS_W-1:0]    auto_capture_echo_loss_time,
   input  wire logic signed [eprl_pkg::LEVEL_W-1:0] rising_rate_threshold,
   input  wire logic signed [eprl_pkg::LEVEL_W-1:0] falling_rate_threshold,
   // display
   input  wire logic [eprl_pkg::SLOT_IDX_W-1:0]   view_slot,
   output logic [eprl_pkg::PROFILE_W-1:0]         view_profile,
   output logic [2:0]                             view_status,
   output logic [eprl_pkg::PROFILE_W-1:0]         buffer_profile,
   output logic                                   buffer_valid,
   output logic [2:0]                             selected_status,
   output logic                                   auto_saved
);
   localparam int N = eprl_pkg::SLOT_COUNT;

   eprl_pkg::eprl_fsm_type                 state_reg;
   logic [eprl_pkg::PROFILE_W-1:0]         slot_data_reg [N];
   logic [2:0]                             slot_status_reg [N];
   logic [eprl_pkg::AGE_W-1:0]             slot_age_reg [N];
   logic [eprl_pkg::AGE_W-1:0]             age_count_reg;
   logic [eprl_pkg::MINUTES_W-1:0]         interval_count_reg;
   logic                                   interval_done_reg;
   logic [eprl_pkg::SECONDS_W-1:0]         loss_count_reg;
   logic                                   loss_long_reg;
   logic                                   sec_tick;
   logic                                   min_tick;
   logic                                   sel_ok;
   logic [eprl_pkg::SLOT_IDX_W-1:0]        sel_idx;
   logic                                   auto_ok;
   logic                                   target_ok;
   logic [eprl_pkg::SLOT_IDX_W-1:0]        target_idx;
   logic                                   source_ok;
   logic                                   band_ok;
   logic                                   dir_ok;
   logic                                   filling;
   logic                                   emptying;
   logic signed [eprl_pkg::LEVEL_W-1:0]    band_lo;
   logic signed [eprl_pkg::LEVEL_W-1:0]    band_hi;

   // slot numbers run one to ten; anything else selects nothing
   function automatic logic slot_valid(input logic [eprl_pkg::SLOT_IDX_W-1:0] s);
      slot_valid = (s != 4'h0) && (s <= 4'(N));
   endfunction

   function automatic logic [eprl_pkg::SLOT_IDX_W-1:0] slot_index(
      input logic [eprl_pkg::SLOT_IDX_W-1:0] s);
      slot_index = s - 4'h1;
   endfunction

   function automatic logic is_auto(input logic [2:0] st);
      is_auto = (st == eprl_pkg::EPRL_ST_A1) || (st == eprl_pkg::EPRL_ST_A2);
   endfunction

   eprl_tick u_tick (
      .clk      (clk),
      .rst      (rst),
      .sec_tick (sec_tick),
      .min_tick (min_tick)
   );

   assign sel_ok  = slot_valid(slot_select);
   assign sel_idx = slot_index(slot_select);

   // source match
   always_comb begin
      case (auto_capture_source_select)
         eprl_pkg::EPRL_SRC_ANY: source_ok = 1'b1;
         eprl_pkg::EPRL_SRC_ONE: source_ok = !profile_point;
         eprl_pkg::EPRL_SRC_TWO: source_ok = profile_point;
         default:                source_ok = 1'b0;
      endcase
   end

   // level band, in whatever order the two setpoints are given
   always_comb begin
      band_lo = (auto_capture_band_on_level < auto_capture_band_off_level) ?
                auto_capture_band_on_level : auto_capture_band_off_level;
      band_hi = (auto_capture_band_on_level < auto_capture_band_off_level) ?
                auto_capture_band_off_level : auto_capture_band_on_level;
      if ((auto_capture_band_on_level == eprl_pkg::LEVEL_UNSET) ||
          (auto_capture_band_off_level == eprl_pkg::LEVEL_UNSET)) begin
         band_ok = 1'b1;
      end else begin
         // setpoints outside the legal range never qualify
         band_ok = (band_lo >= $signed(eprl_pkg::LEVEL_MIN)) &&
                   (band_hi <= $signed(eprl_pkg::LEVEL_MAX)) &&
                   (level_value >= band_lo) && (level_value <= band_hi);
      end
   end

   // direction from rate against indicator thresholds
   assign filling  = level_rate > rising_rate_threshold;
   assign emptying = (-level_rate) > falling_rate_threshold;

   always_comb begin
      case (auto_capture_direction_filter)
         eprl_pkg::EPRL_DIR_EITHER: dir_ok = filling || emptying;
         eprl_pkg::EPRL_DIR_FILL:   dir_ok = filling;
         eprl_pkg::EPRL_DIR_EMPTY:  dir_ok = emptying;
         default:                   dir_ok = 1'b0;
      endcase
   end

   // target: lowest empty slot, else oldest automatic slot
   always_comb begin
      logic [eprl_pkg::AGE_W-1:0] best_age;
      logic                       found_empty;
      target_ok   = 1'b0;
      target_idx  = 4'h0;
      best_age    = 16'hFFFF;
      found_empty = 1'b0;
      for (int i = N - 1; i >= 0; i--) begin
         if (slot_status_reg[i] == eprl_pkg::EPRL_ST_EMPTY) begin
            found_empty = 1'b1;
            target_ok   = 1'b1;
            target_idx  = 4'(i);
         end
      end
      if (!found_empty) begin
         for (int i = 0; i < N; i++) begin
            // manual slots are never candidates
            if (is_auto(slot_status_reg[i]) && (slot_age_reg[i] <= best_age)) begin
               target_ok  = 1'b1;
               target_idx = 4'(i);
               best_age   = slot_age_reg[i];
            end
         end
      end
   end

   assign auto_ok = auto_capture_enable && source_ok && interval_done_reg &&
                    band_ok && dir_ok &&
                    ((auto_capture_echo_loss_time == eprl_pkg::ECHO_LOSS_DEFAULT) ||
                     loss_long_reg) &&
                    target_ok;

   // keypad and capture sequencing
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= eprl_pkg::EPRL_FSM_IDLE;
      end else begin
         case (state_reg)
            eprl_pkg::EPRL_FSM_IDLE: begin
               if (key_capture) begin
                  state_reg <= eprl_pkg::EPRL_FSM_FIRE;
               end else if (key_clear) begin
                  state_reg <= eprl_pkg::EPRL_FSM_CLEARED;
               end else if (profile_valid && auto_ok && !key_save) begin
                  state_reg <= eprl_pkg::EPRL_FSM_AUTO;
               end
            end
            eprl_pkg::EPRL_FSM_FIRE: begin
               if (profile_valid) begin
                  state_reg <= eprl_pkg::EPRL_FSM_IDLE;
               end
            end
            eprl_pkg::EPRL_FSM_CLEARED: begin
               // enter completes the delete; capture or save abandons it, clear keeps waiting
               if (key_enter || key_capture || key_save) begin
                  state_reg <= eprl_pkg::EPRL_FSM_IDLE;
               end
            end
            eprl_pkg::EPRL_FSM_AUTO: begin
               state_reg <= eprl_pkg::EPRL_FSM_IDLE;
            end
            default: begin
               state_reg <= eprl_pkg::EPRL_FSM_IDLE;
            end
         endcase
      end
   end

   assign fire_req = (state_reg == eprl_pkg::EPRL_FSM_FIRE);

   // manual capture buffer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         buffer_profile <= 32'h00000000;
         buffer_valid   <= 1'b0;
      end else if ((state_reg == eprl_pkg::EPRL_FSM_FIRE) && profile_valid) begin
         buffer_profile <= profile_data;
         buffer_valid   <= 1'b1;
      end
   end

   // held capture data for the auto store cycle
   logic [eprl_pkg::PROFILE_W-1:0]  auto_data_reg;
   logic                            auto_point_reg;
   logic [eprl_pkg::SLOT_IDX_W-1:0] auto_idx_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         auto_data_reg  <= 32'h00000000;
         auto_point_reg <= 1'b0;
         auto_idx_reg   <= 4'h0;
      end else if ((state_reg == eprl_pkg::EPRL_FSM_IDLE) && profile_valid) begin
         auto_data_reg  <= profile_data;
         auto_point_reg <= profile_point;
         auto_idx_reg   <= target_idx;
      end
   end

   // slot storage, one generate slice per slot
   generate
      for (genvar g = 0; g < N; g++) begin : g_slot
         logic hit_sel;
         logic hit_auto;
         assign hit_sel  = sel_ok && (sel_idx == 4'(g));
         assign hit_auto = (state_reg == eprl_pkg::EPRL_FSM_AUTO) && (auto_idx_reg == 4'(g));
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               slot_status_reg[g] <= eprl_pkg::EPRL_ST_EMPTY;
               slot_data_reg[g]   <= 32'h00000000;
               slot_age_reg[g]    <= 16'h0000;
            end else if ((state_reg == eprl_pkg::EPRL_FSM_CLEARED) && key_enter &&
                         hit_sel) begin
               slot_status_reg[g] <= eprl_pkg::EPRL_ST_EMPTY;
            end else if ((state_reg == eprl_pkg::EPRL_FSM_IDLE) && key_save &&
                         !key_capture && !key_clear && hit_sel && buffer_valid) begin
               slot_data_reg[g]   <= buffer_profile;
               slot_status_reg[g] <= capture_point ? eprl_pkg::EPRL_ST_U2 :
                                                     eprl_pkg::EPRL_ST_U1;
            end else if (hit_auto) begin
               slot_data_reg[g]   <= auto_data_reg;
               slot_status_reg[g] <= auto_point_reg ? eprl_pkg::EPRL_ST_A2 :
                                                      eprl_pkg::EPRL_ST_A1;
               slot_age_reg[g]    <= age_count_reg;
            end
         end
      end
   endgenerate

   // age stamp grows with each auto save; wrap is not expected in practice
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         age_count_reg <= 16'h0000;
      end else if (state_reg == eprl_pkg::EPRL_FSM_AUTO) begin
         age_count_reg <= age_count_reg + 16'h0001;
      end
   end

   // minimum interval since last auto save, counted in minutes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         interval_count_reg <= 14'h0000;
         interval_done_reg  <= 1'b1;
      end else if (state_reg == eprl_pkg::EPRL_FSM_AUTO) begin
         interval_count_reg <= 14'h0000;
         interval_done_reg  <= (auto_capture_min_interval == 14'h0000);
      end else if (!interval_done_reg && min_tick) begin
         interval_count_reg <= interval_count_reg + 14'h0001;
         if ((interval_count_reg + 14'h0001) >= auto_capture_min_interval) begin
            interval_done_reg <= 1'b1;
         end
      end
   end

   // echo loss duration in seconds; must run past the setting
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         loss_count_reg <= 14'h0000;
         loss_long_reg  <= 1'b0;
      end else if (!echo_loss_condition) begin
         loss_count_reg <= 14'h0000;
         loss_long_reg  <= 1'b0;
      end else if (sec_tick && !loss_long_reg) begin
         loss_count_reg <= loss_count_reg + 14'h0001;
         if (loss_count_reg >= auto_capture_echo_loss_time) begin
            loss_long_reg <= 1'b1;
         end
      end
   end

   // stored raw profile only; results are derived downstream from live settings
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         view_profile    <= 32'h00000000;
         view_status     <= eprl_pkg::EPRL_ST_EMPTY;
         selected_status <= eprl_pkg::EPRL_ST_EMPTY;
         auto_saved      <= 1'b0;
      end else begin
         view_profile    <= slot_valid(view_slot) ?
                            slot_data_reg[slot_index(view_slot)] : 32'h00000000;
         view_status     <= slot_valid(view_slot) ?
                            slot_status_reg[slot_index(view_slot)] : eprl_pkg::EPRL_ST_EMPTY;
         selected_status <= sel_ok ? slot_status_reg[sel_idx] : eprl_pkg::EPRL_ST_EMPTY;
         auto_saved      <= (state_reg == eprl_pkg::EPRL_FSM_AUTO);
      end
   end
endmodule // eprl_library
`default_nettype wire

// ### tb/eprl_library_props.sv
// property checker for the echo profile record library
`timescale 1ns/10ps
`default_nettype none
module eprl_library_props (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // watched ports
   input wire logic        key_capture,
   input wire logic        profile_valid,
   input wire logic [31:0] profile_data,
   input wire logic        auto_capture_enable,
   input wire logic [13:0] auto_capture_min_interval,
   input wire logic        fire_req,
   input wire logic [31:0] buffer_profile,
   input wire logic        buffer_valid,
   input wire logic [2:0]  view_status,
   input wire logic [2:0]  selected_status,
   input wire logic        auto_saved
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   a_fire_holds: assert property (fire_req && !profile_valid |=> fire_req)
      else $error("fire request dropped early");
   a_fire_cause: assert property ($rose(fire_req) |-> $past(key_capture))
      else $error("fire request without capture key");
   a_fire_ends: assert property (fire_req && profile_valid |=> !fire_req)
      else $error("fire request outlived profile");
   a_buffer_load: assert property (fire_req && profile_valid |=>
      buffer_valid && buffer_profile == $past(profile_data))
      else $error("capture buffer not loaded");
   a_buffer_hold: assert property (!(fire_req && profile_valid) |=> $stable(buffer_profile))
      else $error("capture buffer changed");
   a_enable_gates: assert property (!auto_capture_enable [*4] |-> !auto_saved)
      else $error("auto save while disabled");
   a_auto_cause: assert property (auto_saved |-> $past(profile_valid, 2) &&
      $past(auto_capture_enable, 2)) else $error("auto save without enabled profile");
   a_reset_empty: assert property ($fell(rst) |-> view_status == 3'h0 &&
      selected_status == 3'h0 && !buffer_valid && !auto_saved && !fire_req)
      else $error("state survived reset");
   a_interval_wait: assert property (auto_saved && auto_capture_min_interval != 14'h0
      |=> !auto_saved [*8])
      else $error("auto save inside interval");
endmodule // eprl_library_props
bind eprl_library eprl_library_props u_props (.clk, .rst, .key_capture, .profile_valid,
   .profile_data, .auto_capture_enable, .auto_capture_min_interval, .fire_req,
   .buffer_profile, .buffer_valid, .view_status, .selected_status, .auto_saved);
`default_nettype wire

// ### tb/eprl_echo_model.sv
// echo processor model: answers fire requests, pushes profiles
`timescale 1ns/10ps
`default_nettype none
module eprl_echo_model (
   // clock
   input  wire logic  clk,
   // profile interface
   input  wire logic  fire_req,
   output logic       profile_valid,
   output logic [31:0] profile_data,
   output logic       profile_point
);
   logic [31:0] man_data = 32'h0;
   logic        man_point = 1'b0;
   int          wait_n;
   initial begin
      profile_valid = 1'b0;
      profile_data = 32'h0;
      profile_point = 1'b0;
   end
   // released lines show the inverse so stale data never looks valid
   task automatic push(input logic [31:0] d, input logic p);
      @(negedge clk);
      profile_valid = 1'b1;
      profile_data = d;
      profile_point = p;
      @(negedge clk);
      profile_valid = 1'b0;
      profile_data = ~d;
      profile_point = ~p;
   endtask
   // slow or prompt answer to a fire request
   always @(negedge clk) begin
      if (fire_req === 1'b1 && profile_valid === 1'b0) begin
         wait_n = $urandom_range(5);
         repeat (wait_n) @(negedge clk);
         push(man_data, man_point);
      end
   end
endmodule // eprl_echo_model
`default_nettype wire

// ### tb/eprl_library_bench.sv
// self-checking bench for the echo profile record library
`timescale 1ns/10ps
`default_nettype none
module eprl_library_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] slot_select = 4'h0, view_slot = 4'h0;
   logic [3:0] keys = 4'h0;
   logic capture_point = 1'b0;
   logic auto_capture_enable, echo_loss_condition;
   logic [1:0] auto_capture_source_select, auto_capture_direction_filter;
   logic [13:0] auto_capture_min_interval, auto_capture_echo_loss_time;
   logic signed [15:0] level_value, level_rate, rising_rate_threshold, falling_rate_threshold;
   logic signed [15:0] auto_capture_band_on_level, auto_capture_band_off_level;
   logic fire_req, profile_valid, profile_point, buffer_valid, auto_saved;
   logic [31:0] profile_data, view_profile, buffer_profile;
   logic [2:0] view_status, selected_status;
   int st[1:10];
   logic [31:0] dat[1:10];
   int aq[$];
   logic blocked = 1'b0;
   int bad_count = 0;
   int samples_checked = 0;
   always #5 clk = ~clk;
   eprl_echo_model echo (.clk, .fire_req, .profile_valid, .profile_data, .profile_point);
   eprl_library DUT (.clk, .rst, .slot_select, .key_capture(keys[0]), .key_save(keys[2]),
      .key_clear(keys[1]), .key_enter(keys[3]), .capture_point, .fire_req, .profile_valid,
      .profile_data, .profile_point, .level_value, .level_rate, .echo_loss_condition,
      .auto_capture_enable, .auto_capture_source_select, .auto_capture_min_interval,
      .auto_capture_band_on_level, .auto_capture_band_off_level,
      .auto_capture_direction_filter, .auto_capture_echo_loss_time, .rising_rate_threshold,
      .falling_rate_threshold, .view_slot, .view_profile, .view_status, .buffer_profile,
      .buffer_valid, .selected_status, .auto_saved);
   task automatic print_verdict();
      $display("checked %0d bad %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk1(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t flag got %b want %b", $time, got, exp);
      end
   endtask
   task automatic chk3(input logic [2:0] got, input logic [2:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t status got %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t profile got %h want %h", $time, got, exp);
      end
   endtask
   task automatic defaults();
      auto_capture_enable = 1'b1;
      auto_capture_source_select = 2'h0;
      auto_capture_direction_filter = 2'h0;
      auto_capture_min_interval = 14'h0;
      auto_capture_echo_loss_time = 14'h0;
      echo_loss_condition = 1'b0;
      level_value = 16'($urandom_range(900));
      level_rate = 16'sd50;
      rising_rate_threshold = 16'sd10;
      falling_rate_threshold = 16'sd10;
      auto_capture_band_on_level = eprl_pkg::LEVEL_UNSET;
      auto_capture_band_off_level = eprl_pkg::LEVEL_UNSET;
   endtask
   task automatic tap(input int k);
      @(negedge clk);
      keys[k] = 1'b1;
      @(negedge clk);
      keys[k] = 1'b0;
   endtask
   task automatic check_all();
      for (int s = 1; s <= 10; s++) begin
         @(negedge clk);
         view_slot = 4'(s);
         @(negedge clk);
         chk3(view_status, 3'(st[s]));
         if (st[s] != 0) chk32(view_profile, dat[s]);
      end
   endtask
   // model of the qualification; loss time never elapses in this short run
   function automatic logic want(input logic p);
      int r;
      int l;
      logic ok;
      logic band;
      r = level_rate;
      l = level_value;
      if (auto_capture_direction_filter == 2'h1) ok = r > rising_rate_threshold;
      else if (auto_capture_direction_filter == 2'h2) ok = -r > falling_rate_threshold;
      else ok = r > rising_rate_threshold || -r > falling_rate_threshold;
      band = auto_capture_band_on_level == eprl_pkg::LEVEL_UNSET
         || auto_capture_band_off_level == eprl_pkg::LEVEL_UNSET
         || (l - auto_capture_band_on_level) * (l - auto_capture_band_off_level) <= 0;
      ok = ok && band && auto_capture_enable && !blocked && auto_capture_echo_loss_time == 0;
      return ok && (auto_capture_source_select == 2'h0
         || auto_capture_source_select == {1'b0, p} + 2'h1);
   endfunction
   task automatic do_auto(input logic p);
      logic [31:0] d;
      logic seen;
      logic exp;
      int t;
      d = $urandom();
      t = 0;
      for (int s = 10; s >= 1; s--) if (st[s] == 0) t = s;
      if (t == 0 && aq.size() > 0) t = aq[0];
      exp = want(p) && t != 0;
      seen = 1'b0;
      echo.push(d, p);
      repeat (8) begin
         @(negedge clk);
         if (auto_saved === 1'b1) seen = 1'b1;
      end
      chk1(seen, exp);
      if (exp) begin
         if (st[t] != 0) void'(aq.pop_front());
         aq.push_back(t);
         st[t] = p ? 2 : 1;
         dat[t] = d;
         blocked = auto_capture_min_interval != 14'h0;
      end
      check_all();
   endtask
   task automatic manual(input int s, input logic p);
      int n;
      slot_select = 4'(s);
      capture_point = p;
      echo.man_point = p;
      echo.man_data = $urandom();
      tap(0);
      n = 0;
      while (fire_req === 1'b1 && n < 50) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      chk32(buffer_profile, echo.man_data);
      tap(2);
      @(negedge clk);
      chk3(selected_status, p ? 3'h4 : 3'h3);
      st[s] = p ? 4 : 3;
      dat[s] = echo.man_data;
   endtask
   initial begin
      #500_000;
      bad_count++;
      print_verdict();
   end
   initial begin
      void'($urandom(32'hDDD2));
      defaults();
      foreach (st[s]) st[s] = 0;
      repeat (10) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      check_all();
      $display("reset test done");
      manual(3, 1'b1);
      manual(5, 1'b0);
      check_all();
      $display("manual test done");
      for (int i = 0; i < 12; i++) do_auto(1'($urandom_range(1)));
      $display("fill test done");
      // each case bends one condition; the model decides acceptance
      for (int k = 0; k < 13; k++) begin
         defaults();
         case (k)
            0, 1: auto_capture_source_select = 2'h2;
            2, 3: auto_capture_source_select = 2'h1;
            4, 5, 6, 7: begin
               auto_capture_direction_filter = (k < 6) ? 2'h1 : 2'h2;
               level_rate = k[0] ? -16'sd50 : 16'sd50;
            end
            8: level_rate = 16'sd3;
            9: begin
               auto_capture_band_on_level = level_value - 16'sd5;
               auto_capture_band_off_level = level_value + 16'sd5;
            end
            10: begin
               auto_capture_band_on_level = level_value + 16'sd20;
               auto_capture_band_off_level = level_value + 16'sd10;
            end
            11: auto_capture_enable = 1'b0;
            default: begin
               auto_capture_echo_loss_time = 14'h0005;
               echo_loss_condition = 1'b1;
            end
         endcase
         do_auto(k[0]);
      end
      $display("qualify test done");
      defaults();
      slot_select = 4'h3;
      tap(1);
      tap(3);
      st[3] = 0;
      check_all();
      do_auto(1'b0);
      $display("delete test done");
      auto_capture_min_interval = 14'h0001;
      do_auto(1'b1);
      do_auto(1'b0);
      $display("interval test done");
      @(negedge clk);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      foreach (st[s]) st[s] = 0;
      aq.delete();
      blocked = 1'b0;
      check_all();
      do_auto(1'b1);
      $display("power loss test done");
      print_verdict();
   end
endmodule // eprl_library_bench
`default_nettype wire
